// ---- rsf_reset_status.sv ----
// rsf_reset_status: reset cause flags, watchdog enable and watchdog timer.
// assumes reset sources arrive as asynchronous levels and the register port,
// timed-access qualifier and restart come from logic on sys_clk_in.
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ps
module rsf_reset_status
    import rsf_pkg::*;
#(
    parameter int WDT_TIMEOUT_CYCLES = RSF_WDT_TIMEOUT_CYCLES,
    parameter int WDT_HOLD_CYCLES = RSF_WDT_HOLD_CYCLES
) (
    input wire logic sys_clk_in,
    input wire logic reset_n_in,
    input wire logic power_on_req_in,
    input wire logic backup_supply_input_in,
    input wire logic ext_reset_pin_in,
    input wire logic timed_access_in,
    input wire logic [RSF_ADDR_W-1:0] addr_in,
    input wire logic [RSF_DATA_W-1:0] wr_data_in,
    input wire logic wr_strobe_in,
    input wire logic rd_strobe_in,
    output logic [RSF_DATA_W-1:0] rd_data_out,
    output logic internal_reset_line_out,
    output logic watchdog_enable_out,
    output logic watchdog_running_out
);

    localparam int CNT_W = $clog2(WDT_TIMEOUT_CYCLES + 1);
    localparam int HOLD_W = $clog2(WDT_HOLD_CYCLES + 1);
    localparam logic [CNT_W-1:0] TIMEOUT_LAST = CNT_W'(WDT_TIMEOUT_CYCLES - 1);
    localparam logic [HOLD_W-1:0] HOLD_LAST = HOLD_W'(WDT_HOLD_CYCLES - 1);

    generate
        if (WDT_TIMEOUT_CYCLES < 2) begin : g_bad_timeout
            $error("watchdog timeout must be at least two cycles");
        end
        if (WDT_HOLD_CYCLES < 1) begin : g_bad_hold
            $error("watchdog reset hold must be at least one cycle");
        end
        if (RSF_DATA_W != 8) begin : g_bad_data_w
            $error("register image is eight bits wide");
        end
        if (RSF_ADDR_W < 8) begin : g_bad_addr_w
            $error("address port too narrow for the register offsets");
        end
        if (WDT_HOLD_CYCLES >= WDT_TIMEOUT_CYCLES) begin : g_bad_ratio
            $error("watchdog reset hold must be shorter than the timeout");
        end
    endgenerate

    // synchronised reset sources
    logic [2:0] pins_sync;
    logic por_level;
    logic backup_ok;
    logic ext_level;

    rsf_sync #(
        .WIDTH(3)
    ) u_pin_sync (
        .sys_clk_in(sys_clk_in),
        .reset_n_in(reset_n_in),
        .async_in({power_on_req_in, backup_supply_input_in, ext_reset_pin_in}),
        .sync_out(pins_sync)
    );

    assign por_level = pins_sync[2];
    assign backup_ok = pins_sync[1];
    assign ext_level = pins_sync[0];

    // state
    rsf_state_e state;
    rsf_state_e next_state;
    logic [HOLD_W-1:0] hold_count;
    logic [CNT_W-1:0] wdt_count;
    logic por_flag;
    logic watchdog_reset_flag;
    logic watchdog_enable_bit;
    logic [7:0] plain_bits;
    logic [RSF_DATA_W-1:0] rd_data;

    // bus decode
    wire pcs_sel = (addr_in == RSF_PCS_OFFSET);
    wire wdc_sel = (addr_in == RSF_WDC_OFFSET);
    wire in_reset = (state != RSF_IDLE);
    wire pcs_wr = wr_strobe_in && pcs_sel && !in_reset;
    wire wdc_wr = wr_strobe_in && wdc_sel && !in_reset;
    wire pcs_rd = rd_strobe_in && pcs_sel;
    wire wdc_rd = rd_strobe_in && wdc_sel;
    wire pcs_ta_wr = pcs_wr && timed_access_in;
    wire restart_wr = wdc_wr && timed_access_in && wr_data_in[RSF_RESTART_BIT];

    // watchdog status
    // counting only while enabled
    wire wdt_running = watchdog_enable_bit && !in_reset;
    wire wdt_timeout = wdt_running && !restart_wr && (wdt_count == TIMEOUT_LAST);
    wire hold_done = (hold_count == HOLD_LAST);

    // reset kind entry and exit events
    wire enter_por = (state != RSF_IN_POR) && (next_state == RSF_IN_POR);
    wire enter_ext = (state != RSF_IN_EXT) && (next_state == RSF_IN_EXT);
    wire enter_wdt = (state != RSF_IN_WDT) && (next_state == RSF_IN_WDT);
    // supply is judged as the power-on delay ends
    wire exit_por = (state == RSF_IN_POR) && (next_state != RSF_IN_POR);
    wire no_backup_exit = exit_por && !backup_ok;

    // register image assembled field by field
    wire [7:0] por_field = 8'(por_flag) << RSF_POR_BIT;
    wire [7:0] wtr_field = 8'(watchdog_reset_flag) << RSF_WTR_BIT;
    wire [7:0] ewt_field = 8'(watchdog_enable_bit) << RSF_EWT_BIT;
    wire [7:0] pcs_image = plain_bits | por_field | wtr_field | ewt_field;

    // plain-bit images; power-on and watchdog both clear the spare bit
    wire [7:0] plain_full_clr = plain_bits & ~RSF_POR_CLR_MASK;
    wire [7:0] plain_ext_clr = plain_bits & ~RSF_ANY_CLR_MASK;
    wire [7:0] plain_wr_value = wr_data_in & RSF_PLAIN_MASK;
    wire [7:0] wdc_image = 8'(wdt_running) << RSF_RUNNING_BIT;

    // reads never alter the power-on indicator
    // strobes never coincide and offsets differ, so a plain or is safe
    wire [7:0] pcs_rd_value = pcs_rd ? pcs_image : 8'h00;
    wire [7:0] wdc_rd_value = wdc_rd ? wdc_image : 8'h00;
    wire [7:0] next_rd_data = pcs_rd_value | wdc_rd_value;

    // reset sequencer
    // line held while the cause persists, except one low cycle when power-on ends with the pin still held
    // power-on outranks the pin, and the pin outranks the watchdog
    always_comb begin
        next_state = state;
        case (state)
            RSF_IDLE: begin
                if (por_level) begin
                    next_state = RSF_IN_POR;
                end else if (ext_level) begin
                    next_state = RSF_IN_EXT;
                end else if (wdt_timeout) begin
                    next_state = RSF_IN_WDT;
                end
            end
            RSF_IN_POR: begin
                // pin is ignored while power-on runs
                if (!por_level) begin
                    next_state = RSF_IDLE;
                end
            end
            RSF_IN_EXT: begin
                if (por_level) begin
                    next_state = RSF_IN_POR;
                end else if (!ext_level) begin
                    next_state = RSF_IDLE;
                end
            end
            RSF_IN_WDT: begin
                if (por_level) begin
                    next_state = RSF_IN_POR;
                end else if (hold_done) begin
                    next_state = ext_level ? RSF_IN_EXT : RSF_IDLE;
                end
            end
            default: begin
                next_state = RSF_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            state <= RSF_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // watchdog reset pulse length
    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in || state != RSF_IN_WDT) begin
            hold_count <= '0;
        end else if (!hold_done) begin
            hold_count <= hold_count + HOLD_W'(1);
        end
    end

    // watchdog counter, restarted by any reset
    // cleared and frozen when disabled
    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in || !wdt_running || restart_wr || wdt_timeout) begin
            wdt_count <= '0;
        end else begin
            wdt_count <= wdt_count + CNT_W'(1);
        end
    end

    // power-on indicator
    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            por_flag <= RSF_FLAG_RESET;
        end else if (enter_por) begin
            por_flag <= 1'b0;
        end else if (pcs_ta_wr) begin
            por_flag <= wr_data_in[RSF_POR_BIT];
        end
        // other reset kinds leave it alone
    end

    // watchdog-reset indicator; hardware set wins over read clear
    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            watchdog_reset_flag <= RSF_FLAG_RESET;
        end else if (enter_wdt) begin
            watchdog_reset_flag <= 1'b1;
        end else if (enter_por) begin
            watchdog_reset_flag <= 1'b0;
        end else if (pcs_rd) begin
            watchdog_reset_flag <= 1'b0;
        end
        // writes and external reset have no effect
    end

    // watchdog enable bit
    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            watchdog_enable_bit <= RSF_FLAG_RESET;
        end else if (no_backup_exit) begin
            watchdog_enable_bit <= 1'b0;
        end else if (pcs_ta_wr) begin
            watchdog_enable_bit <= wr_data_in[RSF_EWT_BIT];
        end
    end

    // unprotected bits; each reset kind applies its image
    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            plain_bits <= RSF_PCS_RESET;
        // power-on and watchdog clear the spare bit too
        end else if (enter_por || enter_wdt) begin
            plain_bits <= plain_full_clr;
        end else if (enter_ext) begin
            plain_bits <= plain_ext_clr;
        end else if (pcs_wr) begin
            plain_bits <= plain_wr_value;
        end
    end

    // read data stand for one cycle only
    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            rd_data <= '0;
        end else begin
            rd_data <= next_rd_data;
        end
    end

    // no indeterminate bits are kept here; all read as defined values
    assign rd_data_out = rd_data;
    assign internal_reset_line_out = in_reset;
    assign watchdog_enable_out = watchdog_enable_bit;
    assign watchdog_running_out = wdt_running;

endmodule : rsf_reset_status

// ---- rsf_pkg.sv ----
// rsf_pkg: constants and types shared by the reset status flag block.
// assumes an 8-bit special-register space reached over a plain strobe port.
package rsf_pkg;

    // register port geometry
    localparam int RSF_ADDR_W = 8;
    localparam int RSF_DATA_W = 8;

    // register offsets
    localparam logic [7:0] RSF_PCS_OFFSET = 8'h87;
    localparam logic [7:0] RSF_WDC_OFFSET = 8'h8F;

    // field positions in power_control_status
    localparam int RSF_POR_BIT = 6;
    localparam int RSF_WTR_BIT = 4;
    localparam int RSF_EWT_BIT = 2;
    localparam int RSF_SPARE_BIT = 5;

    // field positions in the watchdog control register
    localparam int RSF_RESTART_BIT = 7;
    localparam int RSF_RUNNING_BIT = 0;

    // plain software bits of power_control_status and their reset masks
    localparam logic [7:0] RSF_PLAIN_MASK = 8'hAB;
    localparam logic [7:0] RSF_ANY_CLR_MASK = 8'h8B;
    localparam logic [7:0] RSF_POR_CLR_MASK = 8'hAB;

    // reset values
    localparam logic [7:0] RSF_PCS_RESET = 8'h00;
    localparam logic RSF_FLAG_RESET = 1'b0;

    // timing
    localparam int RSF_CLK_PERIOD_PS = 5000;
    localparam int RSF_CLKS_PER_MC = 1;
    localparam int RSF_WDT_TIMEOUT_MC = 122880;
    localparam int RSF_WDT_TIMEOUT_CYCLES = RSF_WDT_TIMEOUT_MC * RSF_CLKS_PER_MC;
    localparam int RSF_WDT_HOLD_NS = 120;
    localparam int RSF_WDT_HOLD_CYCLES =
        (RSF_WDT_HOLD_NS * 1000 + RSF_CLK_PERIOD_PS - 1) / RSF_CLK_PERIOD_PS;

    // reset sequencer states
    typedef enum logic [1:0] {
        RSF_IDLE,
        RSF_IN_POR,
        RSF_IN_EXT,
        RSF_IN_WDT
    } rsf_state_e;

endpackage : rsf_pkg

// ---- rsf_sync.sv ----
// rsf_sync: two-flop synchroniser for a bundle of independent levels.
// assumes each bit is a slow level; no relation between bits is kept.
`timescale 1ns/1ps
module rsf_sync #(
    parameter int WIDTH = 1
) (
    input wire logic sys_clk_in,
    input wire logic reset_n_in,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1;

    // first stage is read only by the second
    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            stage1 <= '0;
            sync_out <= '0;
        end else begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end

endmodule : rsf_sync

// ---- rsf_reset_status_checker.sv ----
// rsf_reset_status_checker: port-level assertions for rsf_reset_status.
// assumes one clock domain and the synchronous active-low block reset.
`timescale 1ns/1ps
module rsf_reset_status_checker
    import rsf_pkg::*;
#(
    parameter int WDT_TIMEOUT_CYCLES = RSF_WDT_TIMEOUT_CYCLES,
    parameter int WDT_HOLD_CYCLES = RSF_WDT_HOLD_CYCLES
) (
    input wire logic sys_clk_in,
    input wire logic reset_n_in,
    input wire logic power_on_req_in,
    input wire logic backup_supply_input_in,
    input wire logic ext_reset_pin_in,
    input wire logic timed_access_in,
    input wire logic [RSF_ADDR_W-1:0] addr_in,
    input wire logic [RSF_DATA_W-1:0] wr_data_in,
    input wire logic wr_strobe_in,
    input wire logic rd_strobe_in,
    input wire logic [RSF_DATA_W-1:0] rd_data_out,
    input wire logic internal_reset_line_out,
    input wire logic watchdog_enable_out,
    input wire logic watchdog_running_out
);
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!reset_n_in);
    logic pcs_tw;
    logic rst_wr;
    int run_cnt;
    assign pcs_tw = wr_strobe_in && addr_in == RSF_PCS_OFFSET && timed_access_in
        && !internal_reset_line_out;
    assign rst_wr = wr_strobe_in && addr_in == RSF_WDC_OFFSET && timed_access_in
        && wr_data_in[RSF_RESTART_BIT];
    // mirrors the watchdog count; peaks at the timeout as the reset starts
    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in || !watchdog_running_out || rst_wr) begin
            run_cnt <= 0;
        end else begin
            run_cnt <= run_cnt + 1;
        end
    end
    a_read_idle_zero: assert property (
        !rd_strobe_in |=> rd_data_out == 8'h00) else $error("read data outside slot");
    a_running_needs_enable: assert property (
        watchdog_running_out |-> watchdog_enable_out) else $error("running while off");
    a_reset_stops_timer: assert property (
        internal_reset_line_out |-> !watchdog_running_out) else $error("running in reset");
    a_enable_plain_hold: assert property (
        !internal_reset_line_out && !pcs_tw |=> $stable(watchdog_enable_out))
        else $error("enable changed without timed write");
    a_enable_timed_take: assert property (
        pcs_tw |=> watchdog_enable_out == $past(wr_data_in[RSF_EWT_BIT]))
        else $error("timed write not taken");
    a_wdc_read_running: assert property (
        rd_strobe_in && addr_in == RSF_WDC_OFFSET
        |=> rd_data_out == {7'h00, $past(watchdog_running_out)})
        else $error("watchdog control read wrong");
    a_cause_holds_line: assert property (
        (reset_n_in && (ext_reset_pin_in || power_on_req_in))[*5] |-> internal_reset_line_out)
        else $error("reset line low while cause persists");
    a_timeout_bound_cnt: assert property (
        run_cnt <= WDT_TIMEOUT_CYCLES) else $error("watchdog overran timeout");
    a_timeout_fires_reset: assert property (
        run_cnt == WDT_TIMEOUT_CYCLES |-> internal_reset_line_out)
        else $error("no reset at watchdog timeout");
    c_timed_write: cover property (pcs_tw);
    c_restart: cover property (rst_wr && watchdog_running_out);
    c_wdt_fire: cover property (watchdog_running_out ##1 $rose(internal_reset_line_out));
endmodule : rsf_reset_status_checker

bind rsf_reset_status rsf_reset_status_checker #(
    .WDT_TIMEOUT_CYCLES(WDT_TIMEOUT_CYCLES),
    .WDT_HOLD_CYCLES(WDT_HOLD_CYCLES)
) u_chk (.sys_clk_in, .reset_n_in, .power_on_req_in, .backup_supply_input_in,
    .ext_reset_pin_in, .timed_access_in, .addr_in, .wr_data_in, .wr_strobe_in,
    .rd_strobe_in, .rd_data_out, .internal_reset_line_out, .watchdog_enable_out,
    .watchdog_running_out);

// ---- tb_top.sv ----
// tb_top: directed self-checking bench for rsf_reset_status.
// assumes shortened watchdog counts and bench-driven reset sources.
`timescale 1ns/1ps
module tb_top;
    import rsf_pkg::*;
    logic sys_clk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic power_on_req_in = 1'b0;
    logic backup_supply_input_in = 1'b1;
    logic ext_reset_pin_in = 1'b0;
    logic timed_access_in = 1'b0;
    logic [7:0] addr_in = 8'h00;
    logic [7:0] wr_data_in = 8'h00;
    logic wr_strobe_in = 1'b0;
    logic rd_strobe_in = 1'b0;
    logic [7:0] rd_data_out;
    logic internal_reset_line_out;
    logic watchdog_enable_out;
    logic watchdog_running_out;
    int err_total = 0;
    int total_checks = 0;
    int cyc = 0;
    rsf_reset_status #(.WDT_TIMEOUT_CYCLES(64), .WDT_HOLD_CYCLES(4)) DUT (.sys_clk_in,
        .reset_n_in, .power_on_req_in, .backup_supply_input_in, .ext_reset_pin_in,
        .timed_access_in, .addr_in, .wr_data_in, .wr_strobe_in, .rd_strobe_in,
        .rd_data_out, .internal_reset_line_out, .watchdog_enable_out,
        .watchdog_running_out);
    initial begin
        forever #2.5 sys_clk_in = ~sys_clk_in;
    end
    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : complete_run
    // hang guard well above the few hundred cycles the tests need
    always @(posedge sys_clk_in) begin
        cyc++;
        if (cyc == 5000) begin
            err_total++;
            complete_run();
        end
    end
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic ta);
        @(posedge sys_clk_in);
        wr_strobe_in <= 1'b1;
        addr_in <= a;
        wr_data_in <= d;
        timed_access_in <= ta;
        @(posedge sys_clk_in);
        wr_strobe_in <= 1'b0;
        timed_access_in <= 1'b0;
    endtask : wr
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge sys_clk_in);
        rd_strobe_in <= 1'b1;
        addr_in <= a;
        @(posedge sys_clk_in);
        rd_strobe_in <= 1'b0;
        #1;
        chk("read data", rd_data_out, exp);
    endtask : rd_chk
    task automatic wait_line(input logic lvl);
        int n;
        n = 0;
        while (internal_reset_line_out !== lvl && n < 300) begin
            @(posedge sys_clk_in);
            #1;
            n++;
        end
        chk("reset line", {7'h00, internal_reset_line_out}, {7'h00, lvl});
    endtask : wait_line
    // backup level is held until the power-on cycle has ended
    task automatic src_reset(input logic por, input logic bk);
        @(posedge sys_clk_in);
        backup_supply_input_in <= bk;
        power_on_req_in <= por;
        ext_reset_pin_in <= !por;
        wait_line(1'b1);
        repeat (10) @(posedge sys_clk_in);
        power_on_req_in <= 1'b0;
        ext_reset_pin_in <= 1'b0;
        wait_line(1'b0);
        @(posedge sys_clk_in);
        backup_supply_input_in <= 1'b1;
    endtask : src_reset
    task automatic t_writes();
        rd_chk(RSF_PCS_OFFSET, 8'h00);
        rd_chk(RSF_WDC_OFFSET, 8'h00);
        rd_chk(8'h55, 8'h00);
        wr(RSF_PCS_OFFSET, 8'hFF, 1'b0);
        rd_chk(RSF_PCS_OFFSET, 8'hAB);
        wr(RSF_PCS_OFFSET, 8'hFF, 1'b1);
        rd_chk(RSF_PCS_OFFSET, 8'hEF);
        rd_chk(RSF_PCS_OFFSET, 8'hEF);
        chk("running", {7'h00, watchdog_running_out}, 8'h01);
        wr(RSF_PCS_OFFSET, 8'hEB, 1'b1);
        rd_chk(RSF_PCS_OFFSET, 8'hEB);
        chk("running", {7'h00, watchdog_running_out}, 8'h00);
        $display("test writes done");
    endtask : t_writes
    task automatic t_ext();
        src_reset(1'b0, 1'b1);
        rd_chk(RSF_PCS_OFFSET, 8'h60);
        $display("test external reset done");
    endtask : t_ext
    // watchdog image clears bit 5 as well as bits 7, 3, 1 and 0
    task automatic t_wdt();
        wr(RSF_PCS_OFFSET, 8'h64, 1'b1);
        repeat (3) begin
            repeat (40) @(posedge sys_clk_in);
            wr(RSF_WDC_OFFSET, 8'h80, 1'b1);
            #1;
            chk("no early reset", {7'h00, internal_reset_line_out}, 8'h00);
        end
        rd_chk(RSF_WDC_OFFSET, 8'h01);
        wait_line(1'b1);
        wait_line(1'b0);
        src_reset(1'b0, 1'b1);
        rd_chk(RSF_PCS_OFFSET, 8'h54);
        rd_chk(RSF_PCS_OFFSET, 8'h44);
        $display("test watchdog done");
    endtask : t_wdt
    task automatic t_por();
        src_reset(1'b1, 1'b0);
        rd_chk(RSF_PCS_OFFSET, 8'h00);
        wr(RSF_PCS_OFFSET, 8'h44, 1'b1);
        src_reset(1'b1, 1'b1);
        rd_chk(RSF_PCS_OFFSET, 8'h04);
        wr(RSF_PCS_OFFSET, 8'h00, 1'b1);
        #1;
        chk("enable", {7'h00, watchdog_enable_out}, 8'h00);
        $display("test power-on done");
    endtask : t_por
    initial begin
        repeat (10) @(posedge sys_clk_in);
        reset_n_in <= 1'b1;
        t_writes();
        t_ext();
        t_wdt();
        t_por();
        complete_run();
    end
endmodule : tb_top
